// file: verilog/fan_drive_pkg.sv
package fan_drive_pkg;
  // Clock rate
  localparam int unsigned clk_hz = 100_000_000;
  // Output switching rate, Hz
  localparam int unsigned out_pwm_hz = 30_000;
  localparam int unsigned out_pwm_cycles = clk_hz / out_pwm_hz;
  localparam int out_pwm_width = 12;
  // Slowest command: 1 kHz, period 1 ms
  localparam int unsigned cmd_min_hz = 1_000;
  localparam int unsigned cmd_max_hz = 100_000;
  localparam int unsigned cmd_max_period_cycles = clk_hz / cmd_min_hz;
  localparam int period_width = 18;
  // Stop threshold in percent
  localparam int unsigned stop_percent = 5;
  // Consecutive periods agreeing before a stop or start decision
  localparam int unsigned filter_periods = 3;
  // Brake wait, ms (plain default, no figure given)
  localparam int unsigned brake_wait_ms = 500;
  localparam int unsigned brake_wait_cycles = brake_wait_ms * (clk_hz / 1000);
  // Commutation step period, cycles (plain default)
  localparam int unsigned step_cycles = 20_000;
  // Duty resolution
  localparam int duty_width = 8;
  localparam logic [7:0] duty_full = 8'hFF;
  typedef enum logic [1:0] {idle_type_v, wait_v, run_v} dummy_type;
endpackage

// file: verilog/drive_if.sv
`timescale 1ns/10ps
interface drive_if;
  logic [7:0] amplitude;
  logic enable;
  logic [11:0] carrier;
  modport ctrl (output amplitude, output enable, input carrier);
  modport pwm (input amplitude, input enable, output carrier);
endinterface

// file: verilog/out_pwm_gen.sv
`timescale 1ns/10ps
module out_pwm_gen (
  input wire logic mclk,
  input wire logic nrst,
  drive_if.pwm bus
);
  logic [11:0] count;
  localparam logic [11:0] last = 12'(fan_drive_pkg::out_pwm_cycles - 1);

  // Free running carrier, ignores command edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= 12'h000;
    end else if (count == last) begin // [RULE8] [RULE9]
      count <= 12'h000;
    end else begin
      count <= count + 12'h001;
    end
  end
  assign bus.carrier = count;

  property p_wrap;
    @(posedge mclk) disable iff (!nrst)
      count == last |=> count == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) // [RULE8]
    else $error("carrier wrap wrong");
endmodule

// file: verilog/bldc_pwm_speed_control.sv
`timescale 1ns/10ps
// Behaviour
// [RULE1] Command held high gives full speed drive.
// [RULE2] Command held low floats all three phases.
// [RULE3] Drive amplitude follows measured command duty.
// [RULE4] Duty below 5% stops drive; restart only above 5%.
// [RULE5] Stop without standby needs full brake wait before restart.
// [RULE6] Brake wait starts when duty falls below 5%.
// [RULE7] Duty decoded correctly for command rates 1 kHz to 100 kHz.
// [RULE8] Output transistors switch at fixed 30 kHz.
// [RULE9] Output switching free running, unsynchronised to command.
// [RULE10] Host never leaves command floating; pull-up acceptable.
// [RULE11] Tach divide select high gives tach at one third rate.
// [RULE12] Regulation target select: low normal, high low-load.
// [RULE13] Start strength low scales amplitude by duty; high fixes 100%.
// [RULE14] Direction select low forward, high reverse.
// [RULE15] Direction latched only at power-on or leaving standby.
// [RULE16] Forward order a,b,c; reverse order c,b,a.
// [RULE17] Duty measured each period; stop and start decisions filtered.
// [RULE18] Phases float after reset until valid duty above threshold.
module bldc_pwm_speed_control #(
  parameter int unsigned brake_wait = fan_drive_pkg::brake_wait_cycles,
  parameter int unsigned step_len = fan_drive_pkg::step_cycles
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic speed_command,
  input wire logic tach_divide_select,
  input wire logic regulation_target_select,
  input wire logic start_strength_select,
  input wire logic direction_select,
  output logic phase_a_output,
  output logic phase_a_oe,
  output logic phase_b_output,
  output logic phase_b_oe,
  output logic phase_c_output,
  output logic phase_c_oe,
  output logic speed_tach_output,
  output logic low_load_regulation,
  output logic reverse_rotation,
  output logic running
);
  typedef enum {st_off, st_brake, st_start, st_run} state_type;
  localparam int pw = fan_drive_pkg::period_width;
  localparam logic [pw-1:0] max_period =
    pw'(fan_drive_pkg::cmd_max_period_cycles);

  drive_if dbus ();
  out_pwm_gen u_pwm (.mclk(mclk), .nrst(nrst), .bus(dbus));

  ////////////////////////////////////////////////////////////////////////////
  // Duty measurement
  logic cmd_d;
  logic [pw-1:0] period_cnt;
  logic [pw-1:0] high_cnt;
  logic [7:0] duty;
  logic period_done;
  logic stuck;

  function automatic logic [7:0] duty_of(input logic [pw-1:0] hi,
                                         input logic [pw-1:0] per);
    logic [pw+7:0] num;
    num = {hi, 8'h00} - {8'h00, hi};
    duty_of = (per == '0) ? 8'h00 : 8'(num / {8'h00, per});
  endfunction
  assign period_done = speed_command && !cmd_d;
  assign stuck = (period_cnt == max_period);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_d <= 1'b0;
      period_cnt <= '0;
      high_cnt <= '0;
      duty <= 8'h00;
    end else begin
      cmd_d <= speed_command;
      if (period_done) begin // [RULE17] [RULE7]
        duty <= duty_of(high_cnt, period_cnt);
        period_cnt <= pw'(1);
        high_cnt <= pw'(1);
      end else if (stuck) begin // [RULE1] [RULE2]
        duty <= speed_command ? fan_drive_pkg::duty_full : 8'h00;
        period_cnt <= '0;
        high_cnt <= '0;
      end else begin
        period_cnt <= period_cnt + pw'(1);
        high_cnt <= high_cnt + pw'(speed_command);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold filter
  localparam logic [7:0] thresh =
    8'((fan_drive_pkg::stop_percent * 255 + 99) / 100);
  logic [1:0] above_cnt;
  logic [1:0] below_cnt;
  logic duty_ok;
  logic new_sample;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      new_sample <= 1'b0;
    end else begin
      new_sample <= period_done || stuck;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      above_cnt <= 2'h0;
      below_cnt <= 2'h0;
      duty_ok <= 1'b0;
    end else if (new_sample) begin // [RULE17]
      if (duty > thresh) begin
        below_cnt <= 2'h0;
        if (above_cnt == 2'(fan_drive_pkg::filter_periods - 1)) begin
          duty_ok <= 1'b1;
        end else begin
          above_cnt <= above_cnt + 2'h1;
        end
      end else begin
        above_cnt <= 2'h0;
        if (below_cnt == 2'(fan_drive_pkg::filter_periods - 1)) begin
          duty_ok <= 1'b0;
        end else begin
          below_cnt <= below_cnt + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  state_type state;
  logic [31:0] wait_cnt;
  logic standby;
  logic [2:0] step_idx;
  assign standby = (duty == 8'h00);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= st_off; // [RULE18]
      wait_cnt <= 32'h0;
    end else begin
      unique case (state)
        st_off: begin
          if (duty_ok) begin
            state <= st_start;
          end
        end
        st_brake: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (standby) begin
            state <= st_off;
          end else if (duty_ok && wait_cnt >= brake_wait - 1) begin // [RULE5]
            state <= st_start;
          end
        end
        st_start, st_run: begin
          if (!duty_ok) begin // [RULE4] [RULE6]
            state <= st_brake;
            wait_cnt <= 32'h0;
          end else if (state == st_start && step_idx == 3'h5) begin
            state <= st_run;
          end
        end
      endcase
    end
  end

  // Direction captured on leaving standby or off
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reverse_rotation <= 1'b0;
    end else if (state == st_off && duty_ok) begin // [RULE15] [RULE14]
      reverse_rotation <= direction_select;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_load_regulation <= 1'b0;
      running <= 1'b0;
    end else begin
      low_load_regulation <= regulation_target_select; // [RULE12]
      running <= (state == st_start) || (state == st_run);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commutation
  logic [31:0] step_cnt;
  logic [1:0] tach_div;
  logic step_tick;
  assign step_tick = running && (step_cnt >= step_len - 1);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      step_cnt <= 32'h0;
      step_idx <= 3'h0;
    end else if (!running) begin
      step_cnt <= 32'h0;
      step_idx <= 3'h0;
    end else if (step_tick) begin
      step_cnt <= 32'h0;
      step_idx <= (step_idx == 3'h5) ? 3'h0 : step_idx + 3'h1;
    end else begin
      step_cnt <= step_cnt + 32'h1;
    end
  end

  // Tach toggles at steps 2 and 5: twice per electrical cycle undivided, on every third such step when divided
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      speed_tach_output <= 1'b0;
      tach_div <= 2'h0;
    end else if (step_tick && (step_idx == 3'h2 || step_idx == 3'h5)) begin
      if (!tach_divide_select) begin // [RULE11]
        speed_tach_output <= !speed_tach_output;
      end else if (tach_div == 2'h2) begin
        tach_div <= 2'h0;
        speed_tach_output <= !speed_tach_output;
      end else begin
        tach_div <= tach_div + 2'h1;
      end
    end
  end

  // Amplitude: full in strong start, else duty
  assign dbus.amplitude = (state == st_start && start_strength_select) ?
    fan_drive_pkg::duty_full : duty; // [RULE13] [RULE3]
  assign dbus.enable = running;
  logic pwm_on;
  // Carrier scaled by 255 so full amplitude keeps the high side on
  assign pwm_on = ((20'(dbus.carrier) * 20'h000FF) <
    (20'(dbus.amplitude) * 20'(fan_drive_pkg::out_pwm_cycles)));
  // Six step pattern: per phase high, low, or floating
  logic [2:0] hi_sel;
  logic [2:0] lo_sel;
  always_comb begin
    hi_sel = 3'b000;
    lo_sel = 3'b000;
    unique case (step_idx)
      3'h0: begin hi_sel = 3'b001; lo_sel = 3'b010; end
      3'h1: begin hi_sel = 3'b001; lo_sel = 3'b100; end
      3'h2: begin hi_sel = 3'b010; lo_sel = 3'b100; end
      3'h3: begin hi_sel = 3'b010; lo_sel = 3'b001; end
      3'h4: begin hi_sel = 3'b100; lo_sel = 3'b001; end
      default: begin hi_sel = 3'b100; lo_sel = 3'b010; end
    endcase
    if (reverse_rotation) begin // [RULE16]
      hi_sel = {hi_sel[0], hi_sel[1], hi_sel[2]};
      lo_sel = {lo_sel[0], lo_sel[1], lo_sel[2]};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {phase_a_oe, phase_b_oe, phase_c_oe} <= 3'b000;
      {phase_a_output, phase_b_output, phase_c_output} <= 3'b000;
    end else if (!dbus.enable) begin // [RULE2] [RULE4]
      {phase_a_oe, phase_b_oe, phase_c_oe} <= 3'b000;
      {phase_a_output, phase_b_output, phase_c_output} <= 3'b000;
    end else begin
      {phase_c_oe, phase_b_oe, phase_a_oe} <= hi_sel | lo_sel;
      {phase_c_output, phase_b_output, phase_a_output} <=
        pwm_on ? hi_sel : 3'b000; // [RULE1] [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_stop;
    $fell(duty_ok) && state == st_run;
  endsequence
  property p_stop_float;
    @(posedge mclk) disable iff (!nrst)
      s_stop |-> ##3 !phase_a_oe && !phase_b_oe && !phase_c_oe;
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("float"); // [RULE4]
  property p_brake_hold;
    @(posedge mclk) disable iff (!nrst)
      state == st_brake && wait_cnt < brake_wait - 1 |=> state != st_start;
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("early"); // [RULE5]
  property p_reset_float;
    @(posedge mclk) disable iff (!nrst)
      state == st_off |=> !phase_a_oe && !phase_b_oe && !phase_c_oe;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("oe"); // [RULE18]
  property p_dir_hold;
    @(posedge mclk) disable iff (!nrst)
      running && $past(running) |-> $stable(reverse_rotation);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir chg"); // [RULE15]
  property p_idle_float;
    @(posedge mclk) disable iff (!nrst)
      !running |=> !phase_a_oe && !phase_b_oe && !phase_c_oe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("drive"); // [RULE2]
endmodule

// file: test/host_pwm_model.sv
`timescale 1ns/10ps
// Host side speed command source, always driven, never floating
module host_pwm_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [31:0] period_len,
  input wire logic [31:0] high_len,
  output logic speed_command
);
  int cnt;

  // Free running period counter, command rate set by period_len
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
    end else if (cnt + 1 >= period_len) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Solid level at all times, low while in reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      speed_command <= 1'b0;
    end else begin
      speed_command <= (cnt < high_len);
    end
  end
endmodule

// file: test/bldc_pwm_speed_control_test.sv
`timescale 1ns/10ps
`define check(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
  error_cnt++; $display("mismatch %s expected %0h seen %0h", what, exp, got); \
  end end
module bldc_pwm_speed_control_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic speed_command;
  logic tach_sel = 1'b0;
  logic reg_sel = 1'b1;
  logic strength_sel = 1'b1;
  logic dir_sel = 1'b1;
  logic a_out, a_oe, b_out, b_oe, c_out, c_oe;
  logic tach, low_load, reverse, running;
  logic any_oe;
  int period_len = 1000;
  int high_len = 0;
  int error_cnt = 0;
  int compares = 0;
  int tach_edges = 0;
  int hi_cycles = 0;
  int n;

  always #5 mclk = ~mclk;

  host_pwm_model host (.mclk(mclk), .nrst(nrst), .period_len(period_len),
    .high_len(high_len), .speed_command(speed_command));

  bldc_pwm_speed_control #(.brake_wait(20000), .step_len(50)) dut (
    .mclk(mclk), .nrst(nrst), .speed_command(speed_command),
    .tach_divide_select(tach_sel), .regulation_target_select(reg_sel),
    .start_strength_select(strength_sel), .direction_select(dir_sel),
    .phase_a_output(a_out), .phase_a_oe(a_oe), .phase_b_output(b_out),
    .phase_b_oe(b_oe), .phase_c_output(c_out), .phase_c_oe(c_oe),
    .speed_tach_output(tach), .low_load_regulation(low_load),
    .reverse_rotation(reverse), .running(running));

  assign any_oe = a_oe | b_oe | c_oe;

  // Tach edges and high side drive cycles, read as differences
  always @(tach) begin
    tach_edges++;
  end
  always @(negedge mclk) begin
    if (a_out | b_out | c_out) begin
      hi_cycles++;
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Count cycles until running reaches val; bounded
  task automatic wait_run(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (running !== val && cnt < lim) begin
      @(posedge mclk);
      #1 cnt++;
    end
    if (running !== val) begin
      error_cnt++;
      $display("mismatch running wait expected %0h seen %0h", val, running);
      give_verdict();
    end
  endtask

  // Sets the host command, lands just after a clock edge
  task automatic set_cmd(input int per, input int hi);
    @(posedge mclk);
    period_len <= per;
    high_len <= hi;
  endtask

  // OR of all phase enables over a span of cycles
  task automatic scan_oe(input int len, output logic seen);
    seen = 1'b0;
    repeat (len) begin
      @(posedge mclk);
      #1 seen = seen | any_oe;
    end
  endtask

  logic seen;

  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    scan_oe(500, seen);
    `check("running", 1'b0, running)
    `check("phase enable", 1'b0, seen)
    `check("low_load", 1'b1, low_load)
    $display("test reset done");

    set_cmd(1000, 500);
    wait_run(1'b1, 8000, n);
    `check("reverse", 1'b1, reverse)
    @(posedge mclk);
    dir_sel <= 1'b0;
    reg_sel <= 1'b0;
    n = tach_edges;
    scan_oe(3000, seen);
    `check("phase enable", 1'b1, seen)
    `check("tach toggles", 1'b1, (tach_edges - n) inside {[19:21]})
    `check("reverse latched", 1'b1, reverse)
    `check("low_load", 1'b0, low_load)
    $display("test start done");

    set_cmd(1000, 40);
    wait_run(1'b0, 6000, n);
    scan_oe(300, seen);
    `check("phase enable", 1'b0, seen)
    set_cmd(1000, 60);
    wait_run(1'b1, 30000, n);
    `check("brake wait long", 1'b1, n > 15000)
    `check("brake wait short", 1'b1, n < 26000)
    `check("reverse kept in brake", 1'b1, reverse)
    $display("test brake done");

    set_cmd(1000, 1);
    wait_run(1'b0, 6000, n);
    set_cmd(1000, 500);
    wait_run(1'b1, 30000, n);
    `check("no wait after standby", 1'b1, n < 10000)
    `check("forward after standby", 1'b0, reverse)
    $display("test standby done");

    tach_sel <= 1'b1;
    set_cmd(10000, 9990);
    n = tach_edges;
    scan_oe(20000, seen);
    `check("running", 1'b1, running)
    `check("phase enable", 1'b1, seen)
    `check("tach divided", 1'b1, (tach_edges - n) inside {[43:46]})
    set_cmd(100000, 50000);
    n = hi_cycles;
    scan_oe(20000, seen);
    `check("running", 1'b1, running)
    `check("full drive", 1'b1, (hi_cycles - n) > 19500)
    $display("test rate done");
    give_verdict();
  end
endmodule
